// >>> rtl/tocd_pkg.sv
// shared constants and types of the trigger output clock divider
package tocd_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] ADDR_SEL        = 8'h00; // trigger selection
    localparam logic [7:0] ADDR_SRC_RATE   = 8'h04; // source divide rates
    localparam logic [7:0] ADDR_CHK_RATE   = 8'h08; // checker divide rates
    localparam logic [7:0] ADDR_FRAME_LEN0 = 8'h0C; // pattern length ch0
    localparam logic [7:0] ADDR_FRAME_LEN1 = 8'h10; // pattern length ch1
    localparam logic [7:0] ADDR_REF        = 8'h14; // reference and eye cfg
    localparam logic [7:0] ADDR_BIT_RATE   = 8'h18; // bit rate in kbit/s
    localparam logic [7:0] ADDR_EXT_IN     = 8'h1C; // ext input in kHz
    localparam logic [7:0] ADDR_STATUS     = 8'h20; // status flags
    localparam logic [7:0] ADDR_CLK_FREQ   = 8'h24; // bit clock freq kHz

    // field positions
    localparam int SEL_CODE_LSB   = 0;  // selection code [3:0]
    localparam int SEL_CHAN_BIT   = 4;  // selected channel
    localparam int SRC_RATE1_LSB  = 4;  // ch1 source rate [6:4]
    localparam int CHK_RATE1_BIT  = 1;  // ch1 checker rate
    localparam int REF_EYE_BIT    = 2;  // eye scope tracks bit rate
    localparam int ST_REJECT_BIT  = 0;  // selection refused, sticky
    localparam int ST_BITCLK_BIT  = 1;  // bit clock running
    localparam int ST_EXTBAD_BIT  = 2;  // ext input out of range
    localparam int ST_OPT_BIT     = 3;  // clock output option fitted
    localparam int SIXTEENTH_SHIFT = 4; // times 16

    // trigger output selections
    typedef enum logic [3:0] {
        SEL_SRC_DIV1,
        SEL_SRC_DIV2,
        SEL_SRC_DIV4,
        SEL_SRC_DIV8,
        SEL_SRC_DIV16,
        SEL_SRC_DIV64,
        SEL_SRC_FRAME,
        SEL_CHK_DIV4,
        SEL_CHK_DIV8,
        SEL_CHK_DIV16
    } tocd_sel_t;

    // channel divide rates, code is log2 of the denominator
    typedef enum logic [2:0] {
        RATE_1, RATE_2, RATE_4, RATE_8, RATE_16, RATE_32, RATE_64
    } tocd_rate_t;

    // reference clock choices
    typedef enum logic [1:0] {
        REF_INTERNAL, REF_EXT_10M, REF_EXT_SIXTEENTH
    } tocd_ref_t;

    // divide ratios
    localparam logic [31:0] DIV_1  = 32'h0000_0001;
    localparam logic [31:0] DIV_2  = 32'h0000_0002;
    localparam logic [31:0] DIV_4  = 32'h0000_0004;
    localparam logic [31:0] DIV_8  = 32'h0000_0008;
    localparam logic [31:0] DIV_16 = 32'h0000_0010;
    localparam logic [31:0] DIV_64 = 32'h0000_0040;

    // external input window in kHz
    localparam logic [31:0] EXT_MIN_KHZ = 32'h0007_A120;
    localparam logic [31:0] EXT_MAX_KHZ = 32'h000B_EBC2;

    // values after reset
    localparam logic [3:0]  RST_SEL       = 4'h6; // frame marker, legal
    localparam logic [31:0] RST_FRAME_LEN = 32'h0000_007F;
    localparam logic [31:0] RST_BIT_RATE  = 32'h0000_0000;
    localparam logic [31:0] RST_EXT_IN    = 32'h0000_0000;

endpackage : tocd_pkg

// >>> rtl/tocd_divider.sv
// tick counter that pulses once every modulus ticks
`timescale 1ns/10ps
module tocd_divider
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // control
    input  wire logic        restart,
    input  wire logic        tick,
    input  wire logic [31:0] modulus,
    // result
    output logic             pulse
);

    logic [31:0] count;      // ticks seen since last pulse
    logic [31:0] last_index; // modulus minus one, zero guarded
    logic        wrap;       // this tick ends a period

    // a zero modulus acts as one so the output never stalls
    assign last_index = (modulus == 32'h0000_0000) ? 32'h0000_0000
                                                   : modulus - 32'h1;
    assign wrap = tick && (count >= last_index);

    // counter, restart wins so a new setting starts clean
    always_ff @(posedge core_clk)
    begin
        if (rst || restart)
        begin
            count <= 32'h0000_0000;
            pulse <= 1'b0;
        end
        else
        begin
            pulse <= wrap;
            if (wrap)
                count <= 32'h0000_0000;
            else if (tick)
                count <= count + 32'h1;
        end
    end

endmodule : tocd_divider

// >>> rtl/tocd_top.sv
// trigger output selection, division and bit clock output with bus regs
// What this block does
// - divide source 1..64, checker 4..16, marker by length
// - marker pulses once per pattern repetition
// - source choices limited per source divide rate
// - second channel mirrors first with own clocks
// - checker choices limited per checker divide rate
// - no marker while eye scope tracks bit rate
// - fitted option drives undivided bit clock out
// - bit clock only at rates up to 1/8
// - bit clock follows trigger output channel
// - bit clock keeps running while marker selected
// - ten megahertz reference gives freq equal bit rate times rate
// - sixteenth reference gives 16 times input times rate
`timescale 1ns/10ps
module tocd_top
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // bit strobes from channel logic, same clock
    input  wire logic        src_tick_ch0,
    input  wire logic        src_tick_ch1,
    input  wire logic        chk_tick_ch0,
    input  wire logic        chk_tick_ch1,
    // option strap pin
    input  wire logic        clk_opt_fitted_pin,
    // outputs toward the connectors
    output logic             trig_out,
    output logic             bit_clk_out,
    output logic             bit_clk_on
);

    // configuration registers
    logic [3:0]  sel_code;      // current trigger selection
    logic        sel_chan;      // channel of the selection
    logic [2:0]  src_rate0;     // source divide rate ch0
    logic [2:0]  src_rate1;     // source divide rate ch1
    logic        chk_rate0;     // checker divide rate ch0
    logic        chk_rate1;     // checker divide rate ch1
    logic [31:0] frame_len0;    // pattern length ch0 in bits
    logic [31:0] frame_len1;    // pattern length ch1 in bits
    logic [1:0]  ref_mode;      // reference clock choice
    logic        eye_track;     // eye scope data clock tracks bit rate
    logic [31:0] bit_rate;      // configured bit rate kbit/s
    logic [31:0] ext_in;        // external input frequency kHz
    logic        sel_reject;    // sticky, selection refused

    // bus pipeline
    logic        dp_write;      // data phase is a write
    logic [7:0]  dp_addr;       // latched address

    // strap synchroniser
    logic        opt_meta;      // first stage, read by opt_fitted only
    logic        opt_fitted;    // synchronised option strap

    // change detection for divider restart
    logic [9:0]  last_key;      // last seen selection and rates

    // combinational view
    logic        addr_phase;    // valid address phase this cycle
    logic        wr_sel;        // data phase write to selection
    logic [3:0]  new_code;      // requested selection code
    logic        new_chan;      // requested channel
    logic [2:0]  cur_src_rate;  // source rate of selected channel
    logic        cur_chk_rate;  // checker rate of selected channel
    logic [2:0]  new_src_rate;  // source rate of requested channel
    logic        new_chk_rate;  // checker rate of requested channel
    logic        new_legal;     // requested selection allowed
    logic        cur_legal;     // current selection still allowed
    logic        cur_src_tick;  // source strobe of selected channel
    logic        cur_chk_tick;  // checker strobe of selected channel
    logic        is_chk_sel;    // selection uses the checker clock
    logic        div_tick;      // tick fed to the divider
    logic [31:0] cur_frame_len; // pattern length of selected channel
    logic [31:0] modulus;       // ratio for the divider
    logic [9:0]  cfg_key;       // what restarts the divider
    logic        restart;       // restart request
    logic        div_pulse;     // divider output
    logic        bitclk_ok;     // option fitted and rate allow the undivided clock
    logic        ext_bad;       // external input outside window
    logic [31:0] freq_base;     // base of frequency calculation
    logic [31:0] clk_freq;      // reported bit clock frequency
    logic [31:0] rd_mux;        // read data for address phase
    logic        reject_set;    // refused selection this cycle
    logic        reject_clr;    // software clears the flag

    // allowed output per selection and rates
    function automatic logic legal_sel(input logic [3:0] code,
                                       input logic [2:0] srate,
                                       input logic       crate,
                                       input logic       eye);
        logic ok;
        ok = 1'b0;
        unique case (code)
            tocd_pkg::SEL_SRC_DIV1:
                ok = (srate >= tocd_pkg::RATE_8);
            tocd_pkg::SEL_SRC_DIV2:
                ok = (srate == tocd_pkg::RATE_4);
            tocd_pkg::SEL_SRC_DIV4:
                ok = (srate == tocd_pkg::RATE_2);
            tocd_pkg::SEL_SRC_DIV8:
                ok = (srate == tocd_pkg::RATE_1);
            tocd_pkg::SEL_SRC_DIV16:
                ok = (srate <= tocd_pkg::RATE_4);
            tocd_pkg::SEL_SRC_DIV64:
                ok = (srate == tocd_pkg::RATE_1);
            tocd_pkg::SEL_SRC_FRAME:
                ok = !eye;
            tocd_pkg::SEL_CHK_DIV4:
                ok = (crate == 1'b1);
            tocd_pkg::SEL_CHK_DIV8:
                ok = (crate == 1'b0);
            tocd_pkg::SEL_CHK_DIV16:
                ok = 1'b1;
            default:                 // unused codes are refused
                ok = 1'b0;
        endcase
        // rates above 1/64 do not exist
        if (srate > tocd_pkg::RATE_64)
            ok = 1'b0;
        return ok;
    endfunction : legal_sel

    // ratio for a selection
    function automatic logic [31:0] ratio_of(input logic [3:0]  code,
                                             input logic [31:0] flen);
        logic [31:0] r;
        r = tocd_pkg::DIV_1;
        unique case (code)
            tocd_pkg::SEL_SRC_DIV1:  r = tocd_pkg::DIV_1;
            tocd_pkg::SEL_SRC_DIV2:  r = tocd_pkg::DIV_2;
            tocd_pkg::SEL_SRC_DIV4:  r = tocd_pkg::DIV_4;
            tocd_pkg::SEL_SRC_DIV8:  r = tocd_pkg::DIV_8;
            tocd_pkg::SEL_SRC_DIV16: r = tocd_pkg::DIV_16;
            tocd_pkg::SEL_SRC_DIV64: r = tocd_pkg::DIV_64;
            tocd_pkg::SEL_SRC_FRAME: r = flen;
            tocd_pkg::SEL_CHK_DIV4:  r = tocd_pkg::DIV_4;
            tocd_pkg::SEL_CHK_DIV8:  r = tocd_pkg::DIV_8;
            tocd_pkg::SEL_CHK_DIV16: r = tocd_pkg::DIV_16;
            default:                 r = tocd_pkg::DIV_1;
        endcase
        return r;
    endfunction : ratio_of

    // bus decode, every transfer is zero wait and okay
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_sel     = dp_write && (dp_addr == tocd_pkg::ADDR_SEL);
    assign new_code   = hwdata[tocd_pkg::SEL_CODE_LSB +: 4];
    assign new_chan   = hwdata[tocd_pkg::SEL_CHAN_BIT];

    // the second channel uses its own clocks and rates
    assign cur_src_rate = sel_chan ? src_rate1 : src_rate0;
    assign cur_chk_rate = sel_chan ? chk_rate1 : chk_rate0;
    assign new_src_rate = new_chan ? src_rate1 : src_rate0;
    assign new_chk_rate = new_chan ? chk_rate1 : chk_rate0;
    assign cur_src_tick = sel_chan ? src_tick_ch1 : src_tick_ch0;
    assign cur_chk_tick = sel_chan ? chk_tick_ch1 : chk_tick_ch0;
    assign cur_frame_len = sel_chan ? frame_len1 : frame_len0;

    // legality of the request and of what is in force
    assign new_legal = legal_sel(new_code, new_src_rate, new_chk_rate,
                                 eye_track);
    assign cur_legal = legal_sel(sel_code, cur_src_rate, cur_chk_rate,
                                 eye_track);
    assign reject_set = wr_sel && !new_legal;
    assign reject_clr = dp_write && (dp_addr == tocd_pkg::ADDR_STATUS)
                        && hwdata[tocd_pkg::ST_REJECT_BIT];

    // clock source for the divider
    assign is_chk_sel = (sel_code >= tocd_pkg::SEL_CHK_DIV4);
    assign div_tick   = is_chk_sel ? cur_chk_tick : cur_src_tick;
    assign modulus    = ratio_of(sel_code, cur_frame_len);

    // any change of selection, selected channel rate or eye tracking restarts the count
    assign cfg_key = {sel_chan, sel_code, cur_src_rate, cur_chk_rate,
                      eye_track};
    assign restart = (cfg_key != last_key);

    // undivided clock only at the low divide rates
    assign bitclk_ok = opt_fitted
                       && (cur_src_rate <= tocd_pkg::RATE_8);

    // external input window check, reported only
    assign ext_bad = (ref_mode == tocd_pkg::REF_EXT_SIXTEENTH)
                     && ((ext_in < tocd_pkg::EXT_MIN_KHZ)
                      || (ext_in > tocd_pkg::EXT_MAX_KHZ));

    // frequency of the undivided clock in kHz
    assign freq_base = (ref_mode == tocd_pkg::REF_EXT_SIXTEENTH)
                       ? (ext_in << tocd_pkg::SIXTEENTH_SHIFT)
                       : bit_rate;
    // zero when the rate suppresses the clock; no overflow guard, a limitation
    assign clk_freq = (cur_src_rate <= tocd_pkg::RATE_8)
                      ? (freq_base << cur_src_rate)
                      : 32'h0000_0000;

    // read mux, unmapped offsets read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            tocd_pkg::ADDR_SEL:
                rd_mux = {27'h0, sel_chan, sel_code};
            tocd_pkg::ADDR_SRC_RATE:
                rd_mux = {25'h0, src_rate1, 1'b0, src_rate0};
            tocd_pkg::ADDR_CHK_RATE:
                rd_mux = {30'h0, chk_rate1, chk_rate0};
            tocd_pkg::ADDR_FRAME_LEN0:
                rd_mux = frame_len0;
            tocd_pkg::ADDR_FRAME_LEN1:
                rd_mux = frame_len1;
            tocd_pkg::ADDR_REF:
                rd_mux = {29'h0, eye_track, ref_mode};
            tocd_pkg::ADDR_BIT_RATE:
                rd_mux = bit_rate;
            tocd_pkg::ADDR_EXT_IN:
                rd_mux = ext_in;
            tocd_pkg::ADDR_STATUS:
                rd_mux = {28'h0, opt_fitted, ext_bad, bit_clk_on,
                          sel_reject};
            tocd_pkg::ADDR_CLK_FREQ:
                rd_mux = clk_freq;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // address phase capture and read data
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            dp_write  <= addr_phase && hwrite;
            dp_addr   <= haddr[7:0];
            hrdata    <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // selection register, an illegal request leaves it untouched
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sel_code <= tocd_pkg::RST_SEL;
            sel_chan <= 1'b0;
        end
        else if (wr_sel && new_legal)
        begin
            sel_code <= new_code;
            sel_chan <= new_chan;
        end
    end

    // refused flag, a new refusal beats the clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sel_reject <= 1'b0;
        else if (reject_set)
            sel_reject <= 1'b1;
        else if (reject_clr)
            sel_reject <= 1'b0;
    end

    // rates and lengths
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            src_rate0  <= tocd_pkg::RATE_1;
            src_rate1  <= tocd_pkg::RATE_1;
            chk_rate0  <= 1'b0;
            chk_rate1  <= 1'b0;
            frame_len0 <= tocd_pkg::RST_FRAME_LEN;
            frame_len1 <= tocd_pkg::RST_FRAME_LEN;
        end
        else if (dp_write)
        begin
            if (dp_addr == tocd_pkg::ADDR_SRC_RATE)
            begin
                src_rate0 <= hwdata[2:0];
                src_rate1 <= hwdata[tocd_pkg::SRC_RATE1_LSB +: 3];
            end
            if (dp_addr == tocd_pkg::ADDR_CHK_RATE)
            begin
                chk_rate0 <= hwdata[0];
                chk_rate1 <= hwdata[tocd_pkg::CHK_RATE1_BIT];
            end
            if (dp_addr == tocd_pkg::ADDR_FRAME_LEN0)
                frame_len0 <= hwdata;
            if (dp_addr == tocd_pkg::ADDR_FRAME_LEN1)
                frame_len1 <= hwdata;
        end
    end

    // reference and frequency settings
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ref_mode  <= tocd_pkg::REF_INTERNAL;
            eye_track <= 1'b0;
            bit_rate  <= tocd_pkg::RST_BIT_RATE;
            ext_in    <= tocd_pkg::RST_EXT_IN;
        end
        else if (dp_write)
        begin
            if (dp_addr == tocd_pkg::ADDR_REF)
            begin
                ref_mode  <= hwdata[1:0];
                eye_track <= hwdata[tocd_pkg::REF_EYE_BIT];
            end
            if (dp_addr == tocd_pkg::ADDR_BIT_RATE)
                bit_rate <= hwdata;
            if (dp_addr == tocd_pkg::ADDR_EXT_IN)
                ext_in <= hwdata;
        end
    end

    // strap synchroniser, second stage is the only reader of the first
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            opt_meta   <= 1'b0;
            opt_fitted <= 1'b0;
        end
        else
        begin
            opt_meta   <= clk_opt_fitted_pin;
            opt_fitted <= opt_meta;
        end
    end

    // remember configuration to spot changes
    always_ff @(posedge core_clk)
    begin
        if (rst)
            last_key <= 10'h000;
        else
            last_key <= cfg_key;
    end

    // the one divider, shared by all selections
    tocd_divider u_divider
    (
        .core_clk (core_clk),
        .rst      (rst),
        .restart  (restart),
        .tick     (div_tick),
        .modulus  (modulus),
        .pulse    (div_pulse)
    );

    // trigger output, gated if a rate change made the choice illegal
    always_ff @(posedge core_clk)
    begin
        if (rst || restart)
            trig_out <= 1'b0;
        else
            trig_out <= div_pulse && cur_legal;
    end

    // undivided clock from the selected channel source, also while the
    // marker is out; it ignores trigger legality on purpose
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            bit_clk_out <= 1'b0;
            bit_clk_on  <= 1'b0;
        end
        else
        begin
            bit_clk_out <= bitclk_ok && cur_src_tick;
            bit_clk_on  <= bitclk_ok;
        end
    end

endmodule : tocd_top

// >>> tb/tocd_top_chk.sv
// assertion checker for the trigger output clock divider
`timescale 1ns/10ps
module tocd_top_chk
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // bus side
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // channel strobes and strap
    input wire logic        src_tick_ch0,
    input wire logic        src_tick_ch1,
    input wire logic        chk_tick_ch0,
    input wire logic        chk_tick_ch1,
    input wire logic        clk_opt_fitted_pin,
    // connector outputs
    input wire logic        trig_out,
    input wire logic        bit_clk_out,
    input wire logic        bit_clk_on
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // strobes of any source or checker
    wire src_any = src_tick_ch0 | src_tick_ch1;
    wire tick_any = src_any | chk_tick_ch0 | chk_tick_ch1;
    wire rd_take = hsel & htrans[1] & hready & ~hwrite;
    // strap low long enough to pass the synchroniser
    sequence s_strap_off;
        !clk_opt_fitted_pin [*3];
    endsequence
    // bit clock may not rise before the third edge
    sequence s_quiet_two;
        !bit_clk_on && !trig_out ##1 !bit_clk_on;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    a_idle_rdata: assert property (!rd_take |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    a_trig_cause: assert property (trig_out |-> $past(tick_any, 2))
        else $error("trigger without a strobe two cycles back");
    a_bitclk_gated: assert property (bit_clk_out |-> bit_clk_on)
        else $error("bit clock while suppressed");
    a_bitclk_cause: assert property (bit_clk_out |-> $past(src_any))
        else $error("bit clock without source strobe");
    a_strap_off: assert property (s_strap_off |=> !bit_clk_on)
        else $error("bit clock on without option");
    a_release_quiet: assert property ($fell(rst) |-> s_quiet_two)
        else $error("outputs active too soon after reset");
endmodule : tocd_top_chk
bind tocd_top tocd_top_chk tocd_top_chk_i (.core_clk(core_clk), .rst(rst),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .src_tick_ch0(src_tick_ch0), .src_tick_ch1(src_tick_ch1),
    .chk_tick_ch0(chk_tick_ch0), .chk_tick_ch1(chk_tick_ch1),
    .clk_opt_fitted_pin(clk_opt_fitted_pin), .trig_out(trig_out),
    .bit_clk_out(bit_clk_out), .bit_clk_on(bit_clk_on));

// >>> tb/tocd_scope_model.sv
// pulse counting model of the measuring gear at the connectors
`timescale 1ns/10ps
module tocd_scope_model
(
    // clock and control
    input  wire logic   core_clk,
    input  wire logic   clear,
    // connector inputs
    input  wire logic   trig_in,
    input  wire logic   clk_in,
    // counts seen
    output logic [15:0] trig_count,
    output logic [15:0] clk_count
);
    // each high cycle counts as one, so back-to-back high cycles count one per cycle
    always_ff @(posedge core_clk)
    begin
        trig_count <= clear ? 16'h0 : trig_count + 16'(trig_in);
        clk_count <= clear ? 16'h0 : clk_count + 16'(clk_in);
    end
endmodule : tocd_scope_model

// >>> tb/testbench.sv
// self-checking bench for the trigger output clock divider
`timescale 1ns/10ps
module testbench;
    logic        core_clk = 1'b0; // 10 MHz
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        opt_pin = 1'b0; // option strap, fitted later
    logic        clear = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdv;
    logic [3:0]  tk = 4'h0; // chk1 chk0 src1 src0
    logic        hreadyout, hresp, trig_out, bit_clk_out, bit_clk_on;
    logic [15:0] trig_count, clk_count;
    int          miscompares = 0;
    int          tests_run = 0;
    always #50 core_clk = ~core_clk;
    tocd_top tocd_top_i (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src_tick_ch0(tk[0]),
        .src_tick_ch1(tk[1]), .chk_tick_ch0(tk[2]), .chk_tick_ch1(tk[3]),
        .clk_opt_fitted_pin(opt_pin), .trig_out(trig_out),
        .bit_clk_out(bit_clk_out), .bit_clk_on(bit_clk_on));
    tocd_scope_model tocd_scope_model_i (.core_clk(core_clk),
        .clear(clear), .trig_in(trig_out), .clk_in(bit_clk_out),
        .trig_count(trig_count), .clk_count(clk_count));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one single transfer; read data lands in rdv
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus
    // back to back strobes, then count pulses at the gear
    task automatic tick(input logic [3:0] m, input int n, input int tx,
                        input int cx);
        clear <= 1'b0;
        repeat (n) @(posedge core_clk) tk <= m;
        @(posedge core_clk) tk <= 4'h0;
        repeat (4) @(posedge core_clk);
        chk(32'(trig_count), 32'(tx));
        chk(32'(clk_count), 32'(cx));
        clear <= 1'b1;
    endtask : tick
    // reset selection, unmapped place, refused selection, source ratios
    task automatic t_src;
        int r[6] = '{1, 0, 0, 2, 3, 4};
        int c[6] = '{2, 3, 5, 1, 0, 0};
        int n[6] = '{4, 8, 64, 2, 1, 1};
        opt_pin <= 1'b1;
        bus(1'b0, tocd_pkg::ADDR_SEL, 32'h0);
        chk(rdv, 32'h6);
        bus(1'b0, 8'h28, 32'h0);
        chk(rdv, 32'h0);
        bus(1'b1, tocd_pkg::ADDR_SRC_RATE, 32'h1);
        bus(1'b1, tocd_pkg::ADDR_SEL, 32'h0);
        bus(1'b0, tocd_pkg::ADDR_STATUS, 32'h0);
        chk(rdv, 32'hB);
        bus(1'b1, tocd_pkg::ADDR_STATUS, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, tocd_pkg::ADDR_SRC_RATE, 32'(r[i]));
            bus(1'b1, tocd_pkg::ADDR_SEL, 32'(c[i]));
            tick(4'h1, 2 * n[i], 2, r[i] < 4 ? 2 * n[i] : 0);
        end
        $display("source division test done");
    endtask : t_src
    // checker outputs, one per code
    task automatic t_chk;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, tocd_pkg::ADDR_CHK_RATE, 32'(i != 1));
            bus(1'b1, tocd_pkg::ADDR_SEL, 32'(7 + i));
            tick(4'h4, 8 << i, 2, 0);
        end
        $display("checker division test done");
    endtask : t_chk
    // second channel marker, then marker refused under eye tracking
    task automatic t_frame;
        bus(1'b1, tocd_pkg::ADDR_SRC_RATE, 32'h10);
        bus(1'b1, tocd_pkg::ADDR_FRAME_LEN1, 32'h5);
        bus(1'b1, tocd_pkg::ADDR_SEL, 32'h16);
        tick(4'h2, 10, 2, 10);
        bus(1'b1, tocd_pkg::ADDR_REF, 32'h4);
        bus(1'b1, tocd_pkg::ADDR_SEL, 32'h6);
        bus(1'b0, tocd_pkg::ADDR_STATUS, 32'h0);
        chk(rdv, 32'hB);
        bus(1'b0, tocd_pkg::ADDR_SEL, 32'h0);
        chk(rdv, 32'h16);
        $display("marker test done");
    endtask : t_frame
    // bit clock frequency for both external references
    task automatic t_freq;
        bus(1'b1, tocd_pkg::ADDR_REF, 32'h1);
        bus(1'b1, tocd_pkg::ADDR_SRC_RATE, 32'h3);
        bus(1'b1, tocd_pkg::ADDR_SEL, 32'h0);
        bus(1'b1, tocd_pkg::ADDR_BIT_RATE, 32'h0013_12D0);
        bus(1'b0, tocd_pkg::ADDR_CLK_FREQ, 32'h0);
        chk(rdv, 32'h0098_9680);
        bus(1'b1, tocd_pkg::ADDR_REF, 32'h2);
        bus(1'b1, tocd_pkg::ADDR_EXT_IN, 32'h0009_27C0);
        bus(1'b0, tocd_pkg::ADDR_CLK_FREQ, 32'h0);
        chk(rdv, 32'h0009_27C0 << 7);
        opt_pin <= 1'b0;
        bus(1'b1, tocd_pkg::ADDR_SRC_RATE, 32'h4);
        bus(1'b0, tocd_pkg::ADDR_CLK_FREQ, 32'h0);
        chk(rdv, 32'h0);
        $display("frequency test done");
    endtask : t_freq
    // verdict and end of run
    task automatic conclude;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_src;
        t_chk;
        t_frame;
        t_freq;
        conclude;
    end
    // watchdog, about twenty times the expected run
    initial
    begin
        repeat (8000) @(posedge core_clk);
        miscompares++;
        conclude;
    end
endmodule : testbench
